// file: include/ccp_pkg.sv
// Purpose: Shared constants and types for the coprocessor condition sequencer
// Assumes: APB slave with 32-bit data; coprocessor logic on the same clock
// Notes:   Offsets are byte addresses of aligned words
package ccp_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] CCP_OFF_CTRL    = 8'h00;
	localparam logic [7:0] CCP_OFF_STATUS  = 8'h04;
	localparam logic [7:0] CCP_OFF_OPWORD  = 8'h08;
	localparam logic [7:0] CCP_OFF_SELWORD = 8'h0C;
	localparam logic [7:0] CCP_OFF_EXTCNT  = 8'h10;
	localparam logic [7:0] CCP_OFF_SCAN    = 8'h14;
	localparam logic [7:0] CCP_OFF_DISP    = 8'h18;
	localparam logic [7:0] CCP_OFF_COUNTER = 8'h1C;
	localparam logic [7:0] CCP_OFF_NEXTPC  = 8'h20;
	localparam logic [7:0] CCP_OFF_RESP    = 8'h24;

	// Control bits, address word limit
	localparam int CCP_CTRL_START   = 0;
	localparam int CCP_CTRL_SERVICE = 1;
	localparam int CCP_EA_MAX       = 5;

	// ************************************************************
	// Opcode fields and response primitive layout
	// ************************************************************
	localparam logic [3:0]  CCP_FLINE      = 4'hF;
	localparam logic [5:0]  CCP_PAT_DBCC   = 6'b001001;
	localparam logic [5:0]  CCP_PAT_TRAP   = 6'b001111;
	localparam logic [2:0]  CCP_PAT_SCC    = 3'b001;
	localparam logic [1:0]  CCP_PAT_BCC    = 2'b01;
	localparam logic [2:0]  CCP_TRAP_ONE   = 3'b010;
	localparam logic [2:0]  CCP_TRAP_TWO   = 3'b011;
	localparam logic [2:0]  CCP_TRAP_NONE  = 3'b100;
	localparam int          CCP_PRIM_CA    = 15;
	localparam int          CCP_PRIM_VERD  = 0;
	localparam logic [4:0]  CCP_PRIM_NULL  = 5'h00;
	localparam logic [31:0] CCP_CA_SUPPORT = 32'hFFFF_FFFE;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [31:0] CCP_RST_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {
		CCP_BCC, CCP_SCC, CCP_DBCC, CCP_TRAP
	} ccp_kind_t;

	typedef enum logic [2:0] {
		CCP_IDLE, CCP_WR_COND, CCP_RD_RESP, CCP_SERVICE, CCP_COMPLETE
	} ccp_state_t;

	// Request group toward the coprocessor interface registers
	typedef struct packed {
		logic        cond_wr;
		logic        resp_rd;
		logic [2:0]  cop_id;
		logic [15:0] data;
	} ccp_cop_req_t;

endpackage : ccp_pkg

// file: logic/ccp_seq.sv
// Purpose: Main-processor sequencer for coprocessor conditional instructions
// Assumes: Software loads instruction words over APB and starts a run;
//          coprocessor handshake logic shares ref_clk
// Notes:   Service primitives are handed to software, which resumes the run
//
// Summary of operation
// - Branch sends whole opcode word, reads response
// - True branch adds displacement; false goes sequential
// - Word displacement sign-extended to 32 bits
// - Set opcode: id 11-9, 001 in 8-6
// - Set second word holds selector, sent out
// - Set carries zero to five address words
// - Set sends second word, then reads response
// - False writes byte zeros, true writes ones
// - Decrement opcode 001001 in 8-3, register 2-0
// - Decrement/trap second word holds selector
// - Decrement displacement 16-bit, sign-extended
// - Decrement/trap send second word, read response
// - Decrement true leaves counter, goes sequential
// - False decrements low word; -1 falls through
// - Decrement target from displacement word address
// - Trap opcode 001111 in 8-3, opmode 2-0
// - Opmodes 010, 011, 100 valid; others invalid
// - Trap operand words skipped uninterpreted
// - Trap true starts trap; false continues
// - Service primitives serviced, response read again
// - Missing repeat attribute raises protocol violation
// - Opcode needs 1111 in 15-12, id 11-9
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module ccp_seq
	import ccp_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	output ccp_cop_req_t      cop_req,
	input  wire logic         cop_ack,
	input  wire logic [15:0]  cop_resp_data,
	output logic              busy,
	output logic              trap_req
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		ccp_state_t   state;
		ccp_kind_t    kind;
		logic [15:0]  opword;
		logic [15:0]  selword;
		logic [3:0]   ext_cnt;
		logic [2:0]   ea_cnt;
		logic [31:0]  scan;
		logic [31:0]  disp;
		logic [15:0]  counter;
		logic [31:0]  next_pc;
		logic [15:0]  resp;
		logic         busy;
		logic         done;
		logic         finished;
		logic         verdict;
		logic         service;
		logic         illegal;
		logic         proto_err;
		logic         trap;
		logic         byte_store;
		logic [7:0]   byte_val;
		logic         pready;
		logic [31:0]  prdata;
		logic         pslverr;
		ccp_cop_req_t cop;
	} ccp_st_t;

	ccp_st_t st_q;
	ccp_st_t st_d;

	logic        wr_en;
	logic        rd_en;
	logic [31:0] status_w;
	logic [31:0] base_addr;
	logic [31:0] ext_end;
	logic [31:0] sext_disp;
	logic [31:0] branch_off;
	logic [31:0] fall_pc;
	logic [31:0] target_pc;
	logic [15:0] cnt_dec;
	logic [1:0]  trap_ops;
	logic        trap_mode_ok;
	logic [4:0]  prim_type;
	logic        prim_null;
	logic        prim_ca_bad;

	// ************************************************************
	// Bus and address arithmetic
	// ************************************************************
	assign wr_en = psel & penable & st_q.pready & pwrite;
	assign rd_en = psel & penable & ~st_q.pready & ~pwrite;

	assign status_w = {14'h0, st_q.kind, st_q.byte_val, st_q.byte_store,
		st_q.trap, st_q.proto_err, st_q.illegal, st_q.service,
		st_q.verdict, st_q.done, st_q.busy};

	// Extension words start after the opcode for a branch, after the
	// selector word for the others; counts come from software because
	// only the coprocessor design knows them
	assign base_addr = (st_q.kind == CCP_BCC) ? st_q.scan + 32'h0000_0002
		: st_q.scan + 32'h0000_0004;
	assign ext_end   = base_addr + {27'h0, st_q.ext_cnt, 1'b0};
	assign sext_disp = {{16{st_q.disp[15]}}, st_q.disp[15:0]};
	assign branch_off = (st_q.kind == CCP_BCC && st_q.opword[6]) ? st_q.disp
		: sext_disp;
	// Displacement added at the address of its first word
	assign target_pc = ext_end + branch_off;
	assign cnt_dec   = st_q.counter - 16'h0001;

	// Operand words of a trap are counted, never read
	always_comb begin
		trap_ops     = 2'h0;
		trap_mode_ok = 1'b1;
		case (st_q.opword[2:0])
			CCP_TRAP_ONE:  trap_ops = 2'h1;
			CCP_TRAP_TWO:  trap_ops = 2'h2;
			CCP_TRAP_NONE: trap_ops = 2'h0;
			default:       trap_mode_ok = 1'b0;
		endcase
	end

	always_comb begin
		case (st_q.kind)
			CCP_BCC:  fall_pc = ext_end + (st_q.opword[6] ? 32'h0000_0004
				: 32'h0000_0002);
			CCP_SCC:  fall_pc = ext_end + {28'h0, st_q.ea_cnt, 1'b0};
			CCP_DBCC: fall_pc = ext_end + 32'h0000_0002;
			default:  fall_pc = ext_end + {29'h0, trap_ops, 1'b0};
		endcase
	end

	assign prim_type   = cop_resp_data[12:8];
	assign prim_null   = (prim_type == CCP_PRIM_NULL);
	// Repeat attribute is compulsory where the primitive allows it
	assign prim_ca_bad = CCP_CA_SUPPORT[prim_type] & ~cop_resp_data[CCP_PRIM_CA];

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_d = st_q;
		st_d.pready = psel & penable & ~st_q.pready;
		st_d.pslverr = 1'b0;
		st_d.finished = (st_q.state == CCP_COMPLETE);
		if (rd_en) begin
			case (paddr)
				CCP_OFF_STATUS:  st_d.prdata = status_w;
				CCP_OFF_OPWORD:  st_d.prdata = {16'h0, st_q.opword};
				CCP_OFF_SELWORD: st_d.prdata = {16'h0, st_q.selword};
				CCP_OFF_EXTCNT:  st_d.prdata = {25'h0, st_q.ea_cnt, st_q.ext_cnt};
				CCP_OFF_SCAN:    st_d.prdata = st_q.scan;
				CCP_OFF_DISP:    st_d.prdata = st_q.disp;
				CCP_OFF_COUNTER: st_d.prdata = {16'h0, st_q.counter};
				CCP_OFF_NEXTPC:  st_d.prdata = st_q.next_pc;
				CCP_OFF_RESP:    st_d.prdata = {16'h0, st_q.resp};
				CCP_OFF_CTRL:    st_d.prdata = CCP_RST_WORD;
				default: begin
					st_d.prdata  = CCP_RST_WORD;
					st_d.pslverr = 1'b1;
				end
			endcase
		end
		// Word registers stay frozen during a run so the dialogue is stable
		if (wr_en && !st_q.busy) begin
			case (paddr)
				CCP_OFF_OPWORD:  st_d.opword  = pwdata[15:0];
				CCP_OFF_SELWORD: st_d.selword = pwdata[15:0];
				CCP_OFF_EXTCNT: begin
					st_d.ext_cnt = pwdata[3:0];
					st_d.ea_cnt  = (pwdata[6:4] > 3'(CCP_EA_MAX))
						? 3'(CCP_EA_MAX) : pwdata[6:4];
				end
				CCP_OFF_SCAN:    st_d.scan    = pwdata;
				CCP_OFF_DISP:    st_d.disp    = pwdata;
				CCP_OFF_COUNTER: st_d.counter = pwdata[15:0];
				default: ;
			endcase
		end
		// Judged one edge before the write so the error stands with pready
		if (psel && penable && !st_q.pready && pwrite
			&& !(paddr inside {CCP_OFF_CTRL, CCP_OFF_OPWORD,
			CCP_OFF_SELWORD, CCP_OFF_EXTCNT, CCP_OFF_SCAN, CCP_OFF_DISP,
			CCP_OFF_COUNTER})) begin
			st_d.pslverr = 1'b1;
		end

		case (st_q.state)
			CCP_IDLE: begin
				if (wr_en && paddr == CCP_OFF_CTRL && pwdata[CCP_CTRL_START]) begin
					st_d.busy       = 1'b1;
					st_d.done       = 1'b0;
					st_d.verdict    = 1'b0;
					st_d.illegal    = 1'b0;
					st_d.proto_err  = 1'b0;
					st_d.trap       = 1'b0;
					st_d.byte_store = 1'b0;
					st_d.byte_val   = 8'h00;
					st_d.cop.cop_id = st_q.opword[11:9];
					// Decode order matters: the longer patterns share 001
					if (st_q.opword[8:3] == CCP_PAT_DBCC) begin
						st_d.kind = CCP_DBCC;
					end else if (st_q.opword[8:3] == CCP_PAT_TRAP) begin
						st_d.kind = CCP_TRAP;
					end else if (st_q.opword[8:6] == CCP_PAT_SCC) begin
						st_d.kind = CCP_SCC;
					end else begin
						st_d.kind = CCP_BCC;
					end
					if (st_q.opword[15:12] != CCP_FLINE || (st_q.opword[8:3]
						== CCP_PAT_TRAP && !(st_q.opword[2:0] inside {CCP_TRAP_ONE,
						CCP_TRAP_TWO, CCP_TRAP_NONE})) || (st_q.opword[8:6]
						!= CCP_PAT_SCC && st_q.opword[8:7] != CCP_PAT_BCC)) begin
						st_d.illegal = 1'b1;
						st_d.busy    = 1'b0;
						st_d.done    = 1'b1;
					end else begin
						st_d.state       = CCP_WR_COND;
						st_d.cop.cond_wr = 1'b1;
						// Branch sends its opcode word, the rest the selector
						st_d.cop.data = (st_q.opword[8:7] == CCP_PAT_BCC)
							? st_q.opword : st_q.selword;
					end
				end
			end
			CCP_WR_COND: begin
				if (cop_ack) begin
					st_d.cop.cond_wr = 1'b0;
					st_d.cop.resp_rd = 1'b1;
					st_d.state       = CCP_RD_RESP;
				end
			end
			CCP_RD_RESP: begin
				if (cop_ack) begin
					st_d.cop.resp_rd = 1'b0;
					st_d.resp        = cop_resp_data;
					if (prim_null) begin
						st_d.verdict = cop_resp_data[CCP_PRIM_VERD];
						st_d.state   = CCP_COMPLETE;
					end else if (prim_ca_bad) begin
						st_d.proto_err = 1'b1;
						st_d.busy      = 1'b0;
						st_d.done      = 1'b1;
						st_d.state     = CCP_IDLE;
					end else begin
						st_d.service = 1'b1;
						st_d.state   = CCP_SERVICE;
					end
				end
			end
			CCP_SERVICE: begin
				// Software performs the service, then the response is reread
				if (wr_en && paddr == CCP_OFF_CTRL
					&& pwdata[CCP_CTRL_SERVICE]) begin
					st_d.service     = 1'b0;
					st_d.cop.resp_rd = 1'b1;
					st_d.state       = CCP_RD_RESP;
				end
			end
			CCP_COMPLETE: begin
				st_d.next_pc = fall_pc;
				case (st_q.kind)
					CCP_BCC: begin
						if (st_q.verdict) begin
							st_d.next_pc = target_pc;
						end
					end
					CCP_SCC: begin
						st_d.byte_store = 1'b1;
						st_d.byte_val   = {8{st_q.verdict}};
					end
					CCP_DBCC: begin
						// True leaves the counter alone
						if (!st_q.verdict) begin
							st_d.counter = cnt_dec;
							if (cnt_dec != 16'hFFFF) begin
								st_d.next_pc = target_pc;
							end
						end
					end
					default: begin
						st_d.trap = st_q.verdict & trap_mode_ok;
					end
				endcase
				st_d.busy  = 1'b0;
				st_d.done  = 1'b1;
				st_d.state = CCP_IDLE;
			end
			default: st_d.state = CCP_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pready   = st_q.pready;
	assign prdata   = st_q.prdata;
	assign pslverr  = st_q.pslverr;
	assign cop_req  = st_q.cop;
	assign busy     = st_q.busy;
	assign trap_req = st_q.trap;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	logic ok_done;
	assign ok_done = st_q.finished;

	branch_word_out_a: assert property (
		$rose(st_q.cop.cond_wr) && st_q.kind == CCP_BCC
		|-> st_q.cop.data == st_q.opword)
		else $error("branch did not send its opcode word");
	sel_word_out_a: assert property (
		$rose(st_q.cop.cond_wr) && st_q.kind != CCP_BCC
		|-> st_q.cop.data == st_q.selword)
		else $error("selector word not sent");
	resp_follows_a: assert property (
		st_q.cop.cond_wr && cop_ack |=> st_q.cop.resp_rd && !st_q.cop.cond_wr)
		else $error("response read did not follow condition write");
	verdict_first_a: assert property (
		ok_done |-> $past(st_q.resp[12:8], 2) == CCP_PRIM_NULL
		|| st_q.resp[12:8] == CCP_PRIM_NULL)
		else $error("completion without a null primitive");
	set_byte_a: assert property (
		ok_done && st_q.kind == CCP_SCC
		|-> st_q.byte_store && st_q.byte_val == {8{st_q.verdict}})
		else $error("set byte value wrong");
	dec_keep_a: assert property (
		ok_done && st_q.kind == CCP_DBCC && st_q.verdict
		|-> st_q.counter == $past(st_q.counter))
		else $error("counter touched on true verdict");
	dec_count_a: assert property (
		ok_done && st_q.kind == CCP_DBCC && !st_q.verdict
		|-> st_q.counter == 16'($past(st_q.counter) - 16'h0001))
		else $error("counter not decremented by one");
	trap_verdict_a: assert property (
		ok_done && st_q.kind == CCP_TRAP |-> st_q.trap == st_q.verdict)
		else $error("trap request does not follow verdict");
	reread_a: assert property (
		st_q.state == CCP_SERVICE && st_d.state == CCP_RD_RESP
		|=> st_q.cop.resp_rd && !st_q.service)
		else $error("service completion did not reread response");
	ca_missing_a: assert property (
		st_q.cop.resp_rd && cop_ack && !prim_null && prim_ca_bad
		|=> st_q.proto_err && !st_q.busy)
		else $error("missing repeat attribute not flagged");

	branch_taken_c: cover property (ok_done && st_q.kind == CCP_BCC
		&& st_q.verdict);
	dec_loop_c: cover property (ok_done && st_q.kind == CCP_DBCC
		&& !st_q.verdict && st_q.next_pc != $past(fall_pc));
	service_c: cover property ($rose(st_q.service));
	trap_c: cover property ($rose(st_q.trap));

endmodule : ccp_seq

// file: test/ccp_cop_model.sv
// Purpose: Behavioural coprocessor behind the condition/response handshake
// Assumes: Same clock as the sequencer; one request level at a time
// Notes:   Response lines toggle every cycle while no answer is given
`timescale 1ns/1ps
module ccp_cop_model
	import ccp_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  wire ccp_cop_req_t cop_req,
	output logic              cop_ack,
	output logic [15:0]       cop_resp_data,
	input  wire logic         verdict,
	input  wire logic [1:0]   svc_n,
	input  wire logic         bad_ca,
	input  wire logic [1:0]   wait_cy,
	output logic [7:0]        cond_cnt,
	output logic [18:0]       last_cond
);
	// ************
	// Answer logic
	// ************
	logic [1:0] cnt_q;
	logic [1:0] svc_q;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cop_ack       <= 1'b0;
			cnt_q         <= 2'h0;
			svc_q         <= 2'h0;
			cond_cnt      <= 8'h00;
			last_cond     <= 19'h0;
			cop_resp_data <= 16'hA5A5;
		end else if (cop_ack) begin
			cop_ack       <= 1'b0;
			cop_resp_data <= ~cop_resp_data;
		end else if (cop_req.cond_wr || cop_req.resp_rd) begin
			if (cnt_q < wait_cy) begin
				cnt_q         <= cnt_q + 2'h1;
				cop_resp_data <= ~cop_resp_data;
			end else begin
				cnt_q   <= 2'h0;
				cop_ack <= 1'b1;
				if (cop_req.cond_wr) begin
					// Condition write counted; id and word kept for the bench
					cond_cnt  <= cond_cnt + 8'h01;
					last_cond <= {cop_req.cop_id, cop_req.data};
					svc_q     <= svc_n;
				end else if (svc_q != 2'h0) begin
					// Service request, come-again unless told to break it
					svc_q         <= svc_q - 2'h1;
					cop_resp_data <= {~bad_ca, 15'h0100};
				end else begin
					cop_resp_data <= {3'h0, CCP_PRIM_NULL, 7'h00, verdict};
				end
			end
		end else begin
			cop_resp_data <= ~cop_resp_data;
		end
	end
endmodule : ccp_cop_model

// file: test/tb_ccp_seq.sv
// Purpose: Self-checking bench for the condition sequencer
// Assumes: One wait state APB slave; model answers after 0..3 cycles
// Notes:   Instruction placed at 1000h in every case
`timescale 1ns/1ps
module tb_ccp_seq
	import ccp_pkg::*;
;
	typedef struct packed {
		logic [15:0] op;
		logic [15:0] sel;
		logic [7:0]  ext;
		logic [31:0] disp;
		logic [15:0] cnt;
		logic        v;
		logic [1:0]  ns;
		logic        bca;
		logic [31:0] epc;
		logic [15:0] ecnt;
		logic [17:0] est;
	} ccp_case_t;

	logic         ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr, cond_cnt;
	logic [31:0]  pwdata, prdata, q;
	logic         cop_ack, busy, trap_req, verdict, bad_ca, e;
	logic [15:0]  cop_resp_data;
	logic [1:0]   svc_n, wait_cy;
	logic [18:0]  last_cond;
	ccp_cop_req_t cop_req;
	ccp_case_t    cs [14];
	int           fails, checked;

	ccp_seq ccp_seq_inst (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cop_req(cop_req), .cop_ack(cop_ack), .cop_resp_data(cop_resp_data),
		.busy(busy), .trap_req(trap_req));
	ccp_cop_model ccp_cop_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
		.cop_req(cop_req), .cop_ack(cop_ack), .cop_resp_data(cop_resp_data),
		.verdict(verdict), .svc_n(svc_n), .bad_ca(bad_ca),
		.wait_cy(wait_cy), .cond_cnt(cond_cnt), .last_cond(last_cond));

	// ************
	// Tasks
	// ************
	task conclude;
		if (fails == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude

	task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge ref_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask : wr

	task run(input ccp_case_t c, input int i);
		logic [31:0] st, msk;
		logic [7:0]  n0;
		logic        ill;
		wr(CCP_OFF_OPWORD, {16'h0, c.op});
		wr(CCP_OFF_SELWORD, {16'h0, c.sel});
		wr(CCP_OFF_EXTCNT, {24'h0, c.ext});
		wr(CCP_OFF_SCAN, 32'h0000_1000);
		wr(CCP_OFF_DISP, c.disp);
		wr(CCP_OFF_COUNTER, {16'h0, c.cnt});
		verdict <= c.v;
		svc_n   <= c.ns;
		bad_ca  <= c.bca;
		wait_cy <= i[1:0];
		n0 = cond_cnt;
		wr(CCP_OFF_CTRL, 32'h1);
		st = 32'h0;
		for (int k = 0; k < 100; k++) begin
			apb(1'b0, CCP_OFF_STATUS, 32'h0, st, e);
			if (st[1] === 1'b1) break;
			chk("early trap", 32'h0, {31'h0, trap_req});
			if (st[3] === 1'b1) wr(CCP_OFF_CTRL, 32'h2);
		end
		ill = c.est[5:4] != 2'h0;
		msk = ill ? 32'h33 : (c.est[17:16] == 2'd1 ? 32'h3FFF7 : 32'h300F7);
		chk("status", {14'h0, c.est}, st & msk);
		chk("trap_req", {31'h0, c.est[6]}, {31'h0, trap_req});
		chk("cond writes", {31'h0, ~c.est[4]}, {24'h0, cond_cnt - n0});
		if (!ill) begin
			chk("cond word", {13'h0, c.op[11:9], c.est[17:16] == 2'd0 ? c.op : c.sel},
				{13'h0, last_cond});
			apb(1'b0, CCP_OFF_NEXTPC, 32'h0, q, e);
			chk("next pc", c.epc, q);
			apb(1'b0, CCP_OFF_COUNTER, 32'h0, q, e);
			chk("counter", {16'h0, c.ecnt}, q);
		end
	endtask : run

	// ************
	// Sequence
	// ************
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		#200000;
		fails++;
		conclude();
	end

	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{verdict, svc_n, bad_ca, wait_cy} = '0;
		fails = 0;
		checked = 0;
		cs[0]  = '{16'hF695, 16'h0, 8'h01, 32'h0000FFF0, 16'h0, 1'b1, 2'd0, 1'b0, 32'h0FF4, 16'h0, 18'h00006};
		cs[1]  = '{16'hF6C5, 16'h0, 8'h00, 32'hFFFF0000, 16'h0, 1'b0, 2'd1, 1'b0, 32'h1006, 16'h0, 18'h00002};
		cs[2]  = '{16'hF6C5, 16'h0, 8'h00, 32'h00010000, 16'h0, 1'b1, 2'd0, 1'b0, 32'h11002, 16'h0, 18'h00006};
		cs[3]  = '{16'hF668, 16'h12, 8'h31, 32'h0, 16'h0, 1'b1, 2'd2, 1'b0, 32'h100C, 16'h0, 18'h1FF86};
		cs[4]  = '{16'hF668, 16'h12, 8'h31, 32'h0, 16'h0, 1'b0, 2'd0, 1'b0, 32'h100C, 16'h0, 18'h10082};
		cs[5]  = '{16'hF64A, 16'h7, 8'h01, 32'h0000FFFC, 16'h0, 1'b0, 2'd0, 1'b0, 32'h1008, 16'hFFFF, 18'h20002};
		cs[6]  = '{16'hF64A, 16'h7, 8'h01, 32'h0000FFFC, 16'h5, 1'b0, 2'd1, 1'b0, 32'h1002, 16'h4, 18'h20002};
		cs[7]  = '{16'hF64A, 16'h7, 8'h01, 32'h0000FFFC, 16'h5, 1'b1, 2'd0, 1'b0, 32'h1008, 16'h5, 18'h20006};
		cs[8]  = '{16'hF67A, 16'h3, 8'h01, 32'h0, 16'h0, 1'b1, 2'd0, 1'b0, 32'h1008, 16'h0, 18'h30046};
		cs[9]  = '{16'hF67B, 16'h3, 8'h01, 32'h0, 16'h0, 1'b0, 2'd1, 1'b0, 32'h100A, 16'h0, 18'h30002};
		cs[10] = '{16'hF67C, 16'h3, 8'h01, 32'h0, 16'h0, 1'b1, 2'd0, 1'b0, 32'h1006, 16'h0, 18'h30046};
		cs[11] = '{16'hF678, 16'h3, 8'h01, 32'h0, 16'h0, 1'b1, 2'd0, 1'b0, 32'h0, 16'h0, 18'h00012};
		cs[12] = '{16'hE695, 16'h0, 8'h01, 32'h0, 16'h0, 1'b1, 2'd0, 1'b0, 32'h0, 16'h0, 18'h00012};
		cs[13] = '{16'hF668, 16'h12, 8'h31, 32'h0, 16'h0, 1'b1, 2'd1, 1'b1, 32'h0, 16'h0, 18'h00022};
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk("busy after reset", 32'h0, {31'h0, busy});
		for (int i = 0; i < 14; i++) run(cs[i], i);
		chk("busy at end", 32'h0, {31'h0, busy});
		// Unmapped address must raise an error and read zero
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		apb(1'b1, 8'h40, 32'h0, q, e);
		chk("unmapped wr err", 32'h1, {31'h0, e});
		conclude();
	end
endmodule : tb_ccp_seq
